// ==== pkg/mftm_defs.svh ====
// Constants for the multifunction terminal mux: layout, resets, timing.
`ifndef MFTM_DEFS_SVH
`define MFTM_DEFS_SVH
// ----------------------------------------------------------------
// Routing register layout
// ----------------------------------------------------------------
`define MFTM_NTERM 7
`define MFTM_FW 4
`define MFTM_RT_W 28
// Terminal 3 comes up as the serialized interrupt, 6 as clock-run.
`define MFTM_RT_RST 28'h0110111
`define MFTM_SUBSYS_RST 32'h00000000
// ----------------------------------------------------------------
// Serial EEPROM load
// ----------------------------------------------------------------
`define MFTM_EE_DEV_WR 8'hA0
`define MFTM_EE_DEV_RD 8'hA1
`define MFTM_EE_BASE 8'h00
`define MFTM_EE_NBYTES 8
`define MFTM_SCL_QTR_NS 2500
`define MFTM_CLK_MHZ 40
`endif

// ==== pkg/mftm_pkg.sv ====
// Types shared by the multifunction terminal mux files.
package mftm_pkg;
  // Function that a terminal may carry; codes follow declaration order.
  typedef enum logic [3:0] {
    MFTM_FN_ALT,
    MFTM_FN_GPI,
    MFTM_FN_GPO,
    MFTM_FN_LED,
    MFTM_FN_VSW,
    MFTM_FN_AUD,
    MFTM_FN_GEV,
    MFTM_FN_RIO,
    MFTM_FN_D3,
    MFTM_FN_IRQ
  } mftm_func_t;
  // States of the EEPROM loader.
  typedef enum logic [2:0] {
    MFTM_LD_IDLE,
    MFTM_LD_START,
    MFTM_LD_WBIT,
    MFTM_LD_WACK,
    MFTM_LD_RBIT,
    MFTM_LD_RACK,
    MFTM_LD_STOP
  } mftm_ld_t;
endpackage

// ==== hw/mftm_sync.sv ====
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/100ps
module mftm_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Raw pins and filtered levels.
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q; // Stage one feeds stage two only.
  logic [W-1:0] out_d;
  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // A change counts once stages two and three agree.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : dout[i];
    end
  end
  // Registers only.
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= out_d;
    end
  end
endmodule

// ==== hw/mftm_eeprom_loader.sv ====
// Two-wire master that reads a block of defaults from a serial EEPROM.
`timescale 1ns/100ps
`include "mftm_defs.svh"
module mftm_eeprom_loader #(
  parameter int NBYTES = `MFTM_EE_NBYTES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Control and result.
  input wire logic start,
  output logic busy,
  output logic done,
  output logic err,
  output logic [NBYTES*8-1:0] data,
  // Open-drain lines: enable high pulls the line low.
  input wire logic sda_in,
  output logic sda_oe,
  output logic scl_oe
);
  import mftm_pkg::*;
  // Quarter bit period is a least time, so round up.
  localparam int QTR =
    (`MFTM_SCL_QTR_NS * `MFTM_CLK_MHZ + 999) / 1000;
  mftm_ld_t st_q, st_d;
  logic [1:0] ph_q, ph_d, hdr_q, hdr_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] div_q, div_d;
  logic sda_q, sda_d, scl_q, scl_d, err_d, done_d, tick;
  logic [NBYTES*8-1:0] data_d;
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Each bit takes four quarter phases; SCL is high in phases 2 and 3.
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    hdr_d = hdr_q;
    bit_d = bit_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    sda_d = sda_q;
    scl_d = scl_q;
    err_d = err;
    done_d = 1'b0;
    data_d = data;
    tick = (div_q == 16'(QTR - 1));
    div_d = (tick || st_q == MFTM_LD_IDLE) ? 16'h0000 : div_q + 16'h0001;
    if (st_q == MFTM_LD_IDLE) begin
      sda_d = 1'b1;
      scl_d = 1'b1;
      if (start) begin
        st_d = MFTM_LD_START;
        ph_d = 2'h0;
        hdr_d = 2'h0;
        err_d = 1'b0;
      end
    end else if (tick) begin
      ph_d = ph_q + 2'h1;
      if (ph_q == 2'h1) begin
        scl_d = 1'b1;
      end else if (ph_q == 2'h3 && st_q != MFTM_LD_STOP) begin
        scl_d = 1'b0;
      end
      case (st_q)
        MFTM_LD_START: begin
          // Also serves as the repeated start before the read.
          if (ph_q == 2'h0) begin
            sda_d = 1'b1;
          end else if (ph_q == 2'h2) begin
            sda_d = 1'b0;
          end else if (ph_q == 2'h3) begin
            st_d = MFTM_LD_WBIT;
            bit_d = 3'h7;
            sh_d = (hdr_q == 2'h2) ? `MFTM_EE_DEV_RD : `MFTM_EE_DEV_WR;
          end
        end
        MFTM_LD_WBIT: begin
          if (ph_q == 2'h0) begin
            sda_d = sh_q[7];
          end else if (ph_q == 2'h3) begin
            sh_d = {sh_q[6:0], 1'b0};
            bit_d = bit_q - 3'h1;
            if (bit_q == 3'h0) begin
              st_d = MFTM_LD_WACK;
            end
          end
        end
        MFTM_LD_WACK: begin
          if (ph_q == 2'h0) begin
            sda_d = 1'b1;
          end else if (ph_q == 2'h2) begin
            err_d = sda_in; // A missing acknowledge aborts the load.
          end else if (ph_q == 2'h3) begin
            bit_d = 3'h7;
            hdr_d = hdr_q + 2'h1;
            if (err) begin
              st_d = MFTM_LD_STOP;
            end else if (hdr_q == 2'h0) begin
              st_d = MFTM_LD_WBIT;
              sh_d = `MFTM_EE_BASE;
            end else if (hdr_q == 2'h1) begin
              st_d = MFTM_LD_START;
            end else begin
              st_d = MFTM_LD_RBIT;
              cnt_d = 4'h0;
            end
          end
        end
        MFTM_LD_RBIT: begin
          if (ph_q == 2'h0) begin
            sda_d = 1'b1;
          end else if (ph_q == 2'h2) begin
            sh_d = {sh_q[6:0], sda_in};
          end else if (ph_q == 2'h3) begin
            bit_d = bit_q - 3'h1;
            if (bit_q == 3'h0) begin
              st_d = MFTM_LD_RACK;
            end
          end
        end
        MFTM_LD_RACK: begin
          // First byte read lands in the lowest byte of the result.
          if (ph_q == 2'h0) begin
            sda_d = (cnt_q == 4'(NBYTES - 1));
            data_d = {sh_q, data[NBYTES*8-1:8]};
          end else if (ph_q == 2'h3) begin
            bit_d = 3'h7;
            cnt_d = cnt_q + 4'h1;
            st_d = (cnt_q == 4'(NBYTES - 1)) ? MFTM_LD_STOP : MFTM_LD_RBIT;
          end
        end
        MFTM_LD_STOP: begin
          if (ph_q == 2'h0) begin
            sda_d = 1'b0;
          end else if (ph_q == 2'h2) begin
            sda_d = 1'b1;
          end else if (ph_q == 2'h3) begin
            st_d = MFTM_LD_IDLE;
            done_d = ~err;
          end
        end
        default: st_d = MFTM_LD_IDLE;
      endcase
    end
  end
  // Registers only.
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= MFTM_LD_IDLE;
      ph_q <= 2'h0;
      hdr_q <= 2'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      div_q <= 16'h0000;
      sda_q <= 1'b1;
      scl_q <= 1'b1;
      err <= 1'b0;
      done <= 1'b0;
      data <= '0;
      busy <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      hdr_q <= hdr_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      sda_q <= sda_d;
      scl_q <= scl_d;
      err <= err_d;
      done <= done_d;
      data <= data_d;
      busy <= (st_d != MFTM_LD_IDLE);
      sda_oe <= ~sda_d;
      scl_oe <= ~scl_d;
    end
  end
  // A start request leaves idle on the next edge.
  a_ld_starts: assert property (@(posedge clk) disable iff (reset)
    (st_q == MFTM_LD_IDLE && start) |=> busy && st_q == MFTM_LD_START)
    else $error("loader did not start");
endmodule

// ==== hw/mftm_top.sv ====
// Multifunction terminal router, serial load, speaker and suspend logic.
`timescale 1ns/100ps
`include "mftm_defs.svh"
module mftm_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // System pins.
  input wire logic global_reset_in,
  input wire logic pci_reset_in,
  input wire logic suspend_in,
  input wire logic serial_strap_in,
  // Multifunction terminals.
  input wire logic [`MFTM_NTERM-1:0] mux_terminal_i,
  output logic [`MFTM_NTERM-1:0] mux_terminal_o,
  output logic [`MFTM_NTERM-1:0] mux_terminal_oe,
  // Routing configuration.
  input wire logic routing_wr,
  input wire logic [`MFTM_RT_W-1:0] routing_wdata,
  output logic [`MFTM_RT_W-1:0] routing_cfg,
  output logic [31:0] subsystem_id,
  output logic serial_enabled,
  output logic eeprom_busy,
  output logic eeprom_done,
  output logic eeprom_err,
  // Functions routed out to the terminals.
  input wire logic [`MFTM_NTERM-1:0] parallel_irq,
  input wire logic inta_req,
  input wire logic intb_req,
  input wire logic serirq_out,
  input wire logic serirq_out_en,
  input wire logic clkrun_out,
  input wire logic clkrun_out_en,
  input wire logic [4:0] general_output,
  input wire logic socket_activity,
  input wire logic video_switch,
  input wire logic card_audio_pwm,
  input wire logic general_event,
  input wire logic ring_indicate,
  input wire logic low_power_state,
  // Functions sampled from the terminals.
  output logic [4:0] general_input,
  output logic serialized_interrupt_in,
  output logic pci_lock_n,
  output logic clkrun_in,
  // Speaker and wake pins.
  input wire logic [1:0] card_speaker_input,
  input wire logic pme_event,
  input wire logic pme_select,
  output logic host_speaker_output,
  output logic ring_indicate_output
);
  import mftm_pkg::*;
  localparam int NB = `MFTM_EE_NBYTES;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Extract the function field of terminal n.
  function automatic mftm_func_t route_fn(
    input logic [`MFTM_RT_W-1:0] rt, input int n);
    return mftm_func_t'(rt[n*`MFTM_FW +: `MFTM_FW]);
  endfunction
  // True when terminal n may carry function f.
  function automatic logic fn_ok(input int n, input mftm_func_t f);
    logic ok;
    ok = 1'b0;
    case (f)
      MFTM_FN_ALT: ok = (n != 2) && (n != 5);
      MFTM_FN_GPI, MFTM_FN_GPO: ok = (n != 3) && (n != 6);
      MFTM_FN_LED, MFTM_FN_VSW, MFTM_FN_AUD, MFTM_FN_GEV:
        ok = (n != 3) && (n != 6);
      MFTM_FN_RIO: ok = (n == 2) || (n == 4);
      MFTM_FN_D3: ok = (n == 2) || (n == 4) || (n == 5);
      MFTM_FN_IRQ: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction
  // General-purpose bit carried by terminal n.
  function automatic int gp_index(input int n);
    return (n > 3) ? n - 1 : n;
  endfunction
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [12:0] sy_in, sy_out;
  logic glob_rst_s, pci_rst_s, susp_s, strap_s;
  logic [`MFTM_NTERM-1:0] pin_s; // Filtered terminal levels.
  logic [1:0] spk_s;
  assign sy_in = {card_speaker_input, mux_terminal_i, serial_strap_in,
                  suspend_in, pci_reset_in, global_reset_in};
  assign glob_rst_s = sy_out[0];
  assign pci_rst_s = sy_out[1];
  assign susp_s = sy_out[2];
  assign strap_s = sy_out[3];
  assign pin_s = sy_out[10:4];
  assign spk_s = sy_out[12:11];
  mftm_sync #(.W(13)) u_sync (
    .clk(clk),
    .reset(reset),
    .din(sy_in),
    .dout(sy_out)
  );
  // ----------------------------------------------------------------
  // EEPROM loader
  // ----------------------------------------------------------------
  logic ld_start_q, ld_start_d; // One-cycle start pulse.
  logic ld_sda_oe, ld_scl_oe;
  logic [NB*8-1:0] ld_data;
  // A PCI reset in progress aborts any load.
  mftm_eeprom_loader #(.NBYTES(NB)) u_loader (
    .clk(clk),
    .reset(reset | pci_rst_s),
    .start(ld_start_q),
    .busy(eeprom_busy),
    .done(eeprom_done),
    .err(eeprom_err),
    .data(ld_data),
    .sda_in(pin_s[1]),
    .sda_oe(ld_sda_oe),
    .scl_oe(ld_scl_oe)
  );
  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic glob_rst_q, pci_rst_q; // Previous levels for release detection.
  logic soft_clr; // Global or PCI reset, unless suspended.
  logic ser_en_d;
  logic [`MFTM_RT_W-1:0] rt_d;
  logic [31:0] sub_d;
  // Suspend shields the routing and subsystem ID registers from the slower resets; the hard
  // reset input still clears everything.
  always_comb begin
    soft_clr = (glob_rst_s | pci_rst_s) & ~susp_s;
    ser_en_d = serial_enabled;
    if (glob_rst_q && !glob_rst_s) begin
      ser_en_d = ~strap_s;
    end
    ld_start_d = pci_rst_q & ~pci_rst_s & serial_enabled;
    rt_d = routing_cfg;
    sub_d = subsystem_id;
    if (soft_clr) begin
      rt_d = `MFTM_RT_RST;
      sub_d = `MFTM_SUBSYS_RST;
    end else if (eeprom_done) begin
      // Bytes 0..3 carry the subsystem ID, 4..7 the routing defaults.
      sub_d = ld_data[31:0];
      rt_d = ld_data[32 +: `MFTM_RT_W];
    end else if (routing_wr) begin
      rt_d = routing_wdata;
    end
  end
  // Registers only.
  always_ff @(posedge clk) begin
    if (reset) begin
      glob_rst_q <= 1'b0;
      pci_rst_q <= 1'b0;
      serial_enabled <= 1'b0;
      ld_start_q <= 1'b0;
      routing_cfg <= `MFTM_RT_RST;
      subsystem_id <= `MFTM_SUBSYS_RST;
    end else begin
      glob_rst_q <= glob_rst_s;
      pci_rst_q <= pci_rst_s;
      serial_enabled <= ser_en_d;
      ld_start_q <= ld_start_d;
      routing_cfg <= rt_d;
      subsystem_id <= sub_d;
    end
  end
  // ----------------------------------------------------------------
  // Terminal router
  // ----------------------------------------------------------------
  logic [`MFTM_NTERM-1:0] mt_o_d, mt_oe_d;
  logic [4:0] gpi_d;
  logic sirq_d, lock_d, ckr_d, spk_d, ri_d;
  // A terminal whose field names a function it lacks stays undriven.
  always_comb begin
    mftm_func_t f;
    f = MFTM_FN_ALT;
    mt_o_d = '0;
    mt_oe_d = '0;
    gpi_d = general_input;
    sirq_d = 1'b1;
    lock_d = 1'b1;
    ckr_d = 1'b0;
    for (int n = 0; n < `MFTM_NTERM; n++) begin
      f = route_fn(routing_cfg, n);
      if (fn_ok(n, f)) begin
        mt_oe_d[n] = 1'b1;
        case (f)
          MFTM_FN_ALT: begin
            mt_oe_d[n] = 1'b0;
            case (n)
              0: mt_oe_d[n] = inta_req;
              1: mt_oe_d[n] = intb_req;
              3: begin
                mt_o_d[n] = serirq_out;
                mt_oe_d[n] = serirq_out_en;
                sirq_d = pin_s[n];
              end
              4: lock_d = pin_s[n];
              6: begin
                mt_o_d[n] = clkrun_out;
                mt_oe_d[n] = clkrun_out_en;
                ckr_d = pin_s[n];
              end
              default: mt_oe_d[n] = 1'b0;
            endcase
          end
          MFTM_FN_GPI: begin
            mt_oe_d[n] = 1'b0;
            gpi_d[gp_index(n)] = pin_s[n];
          end
          MFTM_FN_GPO: mt_o_d[n] = general_output[gp_index(n)];
          MFTM_FN_LED: mt_o_d[n] = socket_activity;
          MFTM_FN_VSW: mt_o_d[n] = video_switch;
          MFTM_FN_AUD: mt_o_d[n] = card_audio_pwm;
          MFTM_FN_GEV: mt_o_d[n] = ~general_event;
          MFTM_FN_RIO: mt_o_d[n] = ~ring_indicate;
          MFTM_FN_D3: mt_o_d[n] = low_power_state;
          MFTM_FN_IRQ: mt_o_d[n] = parallel_irq[n];
          default: mt_oe_d[n] = 1'b0;
        endcase
      end
    end
    // The serial interface takes over terminals 1 and 4 outright.
    if (serial_enabled) begin
      mt_o_d[1] = 1'b0;
      mt_oe_d[1] = ld_sda_oe;
      mt_o_d[4] = 1'b0;
      mt_oe_d[4] = ld_scl_oe;
      lock_d = 1'b1;
      gpi_d[1] = general_input[1];
      gpi_d[3] = general_input[3];
    end
    spk_d = spk_s[0] ^ spk_s[1];
    ri_d = pme_select ? ~pme_event : ~ring_indicate;
  end
  // Registers only; every terminal, sampled-function, speaker and wake output leaves from here.
  always_ff @(posedge clk) begin
    if (reset) begin
      mux_terminal_o <= '0;
      mux_terminal_oe <= '0;
      general_input <= 5'h00;
      serialized_interrupt_in <= 1'b1;
      pci_lock_n <= 1'b1;
      clkrun_in <= 1'b0;
      host_speaker_output <= 1'b0;
      ring_indicate_output <= 1'b1;
    end else begin
      mux_terminal_o <= mt_o_d;
      mux_terminal_oe <= mt_oe_d;
      general_input <= gpi_d;
      serialized_interrupt_in <= sirq_d;
      pci_lock_n <= lock_d;
      clkrun_in <= ckr_d;
      host_speaker_output <= spk_d;
      ring_indicate_output <= ri_d;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_spk_xor: assert property (@(posedge clk) disable iff (reset)
    ##1 host_speaker_output == ($past(spk_s[0]) ^ $past(spk_s[1])))
    else $error("speaker output is not the slot XOR");
  a_rt_default: assert property (@(posedge clk)
    reset |=> route_fn(routing_cfg, 3) == MFTM_FN_ALT)
    else $error("terminal 3 not serialized interrupt after reset");
  a_susp_hold: assert property (@(posedge clk) disable iff (reset)
    (susp_s && !eeprom_done && !routing_wr) |=> $stable(routing_cfg))
    else $error("routing lost while suspended");
  a_sda_route: assert property (@(posedge clk) disable iff (reset)
    serial_enabled |=> mux_terminal_oe[1] == $past(ld_sda_oe)
      && !mux_terminal_o[1])
    else $error("terminal 1 is not carrying SDA");
  a_scl_route: assert property (@(posedge clk) disable iff (reset)
    serial_enabled |=> mux_terminal_oe[4] == $past(ld_scl_oe)
      && !mux_terminal_o[4])
    else $error("terminal 4 is not carrying SCL");
  a_gpo_drive: assert property (@(posedge clk) disable iff (reset)
    route_fn(routing_cfg, 0) == MFTM_FN_GPO |=> mux_terminal_oe[0]
      && mux_terminal_o[0] == $past(general_output[0]))
    else $error("terminal 0 not driving general output 0");
  a_no_drive: assert property (@(posedge clk) disable iff (reset)
    !fn_ok(2, route_fn(routing_cfg, 2)) |=> !mux_terminal_oe[2])
    else $error("terminal 2 drives an unselectable function");
  a_clkrun: assert property (@(posedge clk) disable iff (reset)
    route_fn(routing_cfg, 6) == MFTM_FN_ALT |=>
      mux_terminal_oe[6] == $past(clkrun_out_en))
    else $error("terminal 6 not following clock-run");
  a_ring_indicate_output: assert property (@(posedge clk) disable iff (reset)
    pme_select |=> ring_indicate_output == !$past(pme_event))
    else $error("wake pin not carrying the power event");
  a_load_go: assert property (@(posedge clk) disable iff (reset)
    (pci_rst_q && !pci_rst_s && serial_enabled) |=> ##1 eeprom_busy)
    else $error("EEPROM load did not follow PCI reset release");
endmodule

// ==== dv/mftm_ee_model.sv ====
// Behavioural serial EEPROM that answers the defaults load.
`timescale 1ns/100ps
module mftm_ee_model (
  // Wire levels and a refusal control.
  input wire logic scl,
  input wire logic sda,
  input wire logic nack_dev,
  // High pulls the data line low.
  output logic pull
);
  logic [7:0] sh, ptr, cur;
  logic rd, first, go, dp;
  int n;
  // A ramp, so that a byte-order slip shows.
  function automatic logic [7:0] rom(input logic [7:0] a);
    return 8'h3C + 8'h11 * a;
  endfunction
  initial begin
    {pull, rd, first, go, dp, sh, ptr, cur} = '0;
    n = 0;
  end
  // Start: data falls while the clock is high.
  always @(negedge sda) if (scl === 1'b1) begin
    n = 0;
    dp = 0;
    first = 1;
    go = 1;
  end
  // Stop ends the transfer at once; pull is left as it is.
  always @(posedge sda) if (scl === 1'b1) go = 0;
  always @(posedge scl) if (go) begin
    sh = {sh[6:0], sda};
    n = n + 1;
  end
  // Line changes only while the clock is low.
  always @(negedge scl) if (go) begin
    cur = rom(ptr);
    if (n == 8 && !dp) begin
      pull = !(first && (nack_dev || sh[7:1] != 7'h50));
      if (first) rd = sh[0];
      else ptr = sh;
      first = 0;
    end else if (n == 8) begin
      pull = 0;
    end else if (n == 9) begin
      n = 0;
      if (dp) ptr = ptr + 1;
      if (dp && sh[0]) go = 0;
      dp = rd && go;
      cur = rom(ptr);
      pull = dp && !cur[7];
    end else if (dp) begin
      pull = !cur[7-n];
    end
  end
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the multifunction terminal mux.
`timescale 1ns/100ps
`include "mftm_defs.svh"
module tb_top;
  logic clk, reset, glob_rst, pci_rst, susp, strap, wr, nack, pull;
  logic inta, intb, sq, sq_en, cr, cr_en, led, vsw, aud, gev, ring, d3;
  logic pme, psel, ser_en, busy, done, err, sii, lock_n, cri, spk_o, ri_o;
  logic [27:0] wdata, cfg;
  logic [31:0] sid;
  logic [6:0] tin, pin, t_o, t_oe, pirq;
  logic [4:0] gpo, gpi;
  logic [2:0] st;
  logic [1:0] spk;
  int checks = 0;
  int fail_count = 0;
  int cyc = 0;
  // A driven pin shows the driven level, an idle one the outside level;
  // the EEPROM model can also pull terminal 1 low.
  assign pin = ((t_oe & t_o) | (~t_oe & tin)) & ~{5'h00, pull, 1'h0};
  assign st = {err, done, busy};
  mftm_top uut (.clk(clk), .reset(reset), .global_reset_in(glob_rst),
    .pci_reset_in(pci_rst), .suspend_in(susp), .serial_strap_in(strap),
    .mux_terminal_i(pin), .mux_terminal_o(t_o), .mux_terminal_oe(t_oe),
    .routing_wr(wr), .routing_wdata(wdata), .routing_cfg(cfg),
    .subsystem_id(sid), .serial_enabled(ser_en), .eeprom_busy(busy),
    .eeprom_done(done), .eeprom_err(err), .parallel_irq(pirq),
    .inta_req(inta), .intb_req(intb), .serirq_out(sq),
    .serirq_out_en(sq_en), .clkrun_out(cr), .clkrun_out_en(cr_en),
    .general_output(gpo), .socket_activity(led), .video_switch(vsw),
    .card_audio_pwm(aud), .general_event(gev), .ring_indicate(ring),
    .low_power_state(d3), .general_input(gpi),
    .serialized_interrupt_in(sii), .pci_lock_n(lock_n),
    .clkrun_in(cri), .card_speaker_input(spk), .pme_event(pme),
    .pme_select(psel), .host_speaker_output(spk_o),
    .ring_indicate_output(ri_o));
  mftm_ee_model ee (.scl(pin[4]), .sda(pin[1]), .nack_dev(nack),
    .pull(pull));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // Inputs move a fixed 2 ns after the rising edge.
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write the routing, then check readback and the driven pins.
  task automatic route(input logic [27:0] v, input logic [6:0] eo,
                       input logic [6:0] eoe, input logic [6:0] m);
    wr = 1;
    wdata = v;
    tick(1);
    wr = 0;
    tick(2);
    chk(cfg, v);
    chk(t_oe & m, eoe);
    chk(t_o & eoe, eo);
  endtask
  // Pin resets are synchronised, so hold them well past the lag.
  task automatic pulse(input logic g, input logic p);
    glob_rst = g;
    pci_rst = p;
    tick(6);
    glob_rst = 0;
    pci_rst = 0;
    tick(8);
  endtask
  task automatic wait_hi(input int b, input int lim);
    for (int i = 0; i < lim && st[b] !== 1'b1; i++) tick(1);
  endtask
  task automatic complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cuts a hang short; the load itself needs about 41000 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    {reset, strap} = 2'h3;
    {glob_rst, pci_rst, susp, wr, nack, sq, vsw, pme, psel} = '0;
    {inta, intb, sq_en, cr, cr_en, led, aud, gev, ring, d3} = '1;
    {wdata, tin, pirq, gpo, spk} = {28'h0, 7'h7F, 7'h55, 5'h15, 2'h0};
    tick(12);
    reset = 0;
    tick(1);
    chk(cfg, `MFTM_RT_RST);
    chk(ser_en, 1'h0);
    route(28'h2222222, 7'h25, 7'h37, 7'h7F);
    route(28'h0000000, 7'h40, 7'h4B, 7'h7F);
    // Alternate inputs are sampled back through the synchroniser.
    tin = 7'h6F;
    tick(6);
    chk(sii, 1'h0);
    chk(lock_n, 1'h0);
    chk(cri, 1'h1);
    route(28'h9689743, 7'h11, 7'h37, 7'h37);
    route(28'h8012065, 7'h01, 7'h03, 7'h7F);
    route(28'h1111111, 7'h00, 7'h00, 7'h7F);
    tin = 7'h2D;
    tick(8);
    chk(gpi, 5'h15);
    tin = 7'h7F;
    for (int i = 0; i < 4; i++) begin
      spk = i[1:0];
      tick(8);
      chk(spk_o, ^spk);
    end
    for (int i = 0; i < 8; i++) begin
      {psel, pme, ring} = i[2:0];
      tick(8);
      chk(ri_o, psel ? !pme : !ring);
    end
    susp = 1;
    tick(8);
    pulse(1, 0);
    pulse(0, 1);
    chk(cfg, 28'h1111111);
    susp = 0;
    pulse(0, 1);
    chk(cfg, `MFTM_RT_RST);
    strap = 0;
    pulse(1, 0);
    chk(ser_en, 1'h1);
    pulse(0, 1);
    wait_hi(0, 50);
    tick(2000);
    chk({busy, t_o[1], t_o[4]}, 3'h4);
    wait_hi(1, 60000);
    tick(2);
    chk(sid, 32'h6F5E4D3C);
    chk({err, cfg}, {1'h0, 28'h3A29180});
    nack = 1;
    pulse(0, 1);
    wait_hi(2, 10000);
    tick(2);
    chk({err, sid}, {1'h1, 32'h0});
    complete_run();
  end
endmodule
